// ### test/mis_host_model.sv
// Serial host model for the two-wire register port of the monitor block.
// Assumes sys_clk pacing and a pull-up on SDA, so a released line reads high.
`timescale 1ns/1ns
module mis_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2C
) (
  input wire logic sys_clk,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda_in
);
  // ==========================================================================
  // Bus wire and bit phases.
  logic sda_h = 1'b1;
  int nacks = 0;

  // Either party pulling low wins; otherwise the pull-up holds the line high.
  assign sda_in = sda_h & (sda_oe_n | sda_out);

  // SCL idles high and stands still between frames.
  initial scl = 1'b1;

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // Six cycles low and six high, above the five-cycle minimum the port needs.
  task automatic bit_io(input logic b, output logic s);
    tick(3);
    sda_h = b;
    tick(3);
    scl = 1'b1;
    tick(3);
    s = sda_in;
    tick(3);
    scl = 1'b0;
  endtask : bit_io

  // Works from idle and as a repeated start with SCL low.
  task automatic start;
    tick(3);
    sda_h = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(6);
    sda_h = 1'b0;
    tick(6);
    scl = 1'b0;
  endtask : start

  task automatic stop;
    tick(3);
    sda_h = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(6);
    sda_h = 1'b1;
    tick(6);
  endtask : stop

  // Eight bits MSB first, then a released ninth bit; a high ninth bit on a write is a refusal.
  task automatic xfer(input logic [7:0] b, input logic wr_dir, output logic [7:0] r);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
      r[i] = s;
    end
    bit_io(1'b1, s);
    if (wr_dir && s) nacks++;
  endtask : xfer

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r);
    xfer(ofs, 1'b1, r);
    xfer(d, 1'b1, r);
    stop();
  endtask : wr

  // Pointer write, repeated start, one byte read and a closing NACK.
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r);
    xfer(ofs, 1'b1, r);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, r);
    xfer(8'hFF, 1'b0, d);
    stop();
  endtask : rd
endmodule : mis_host_model

// ### test/mis_irq_top_tb.sv
// Self-checking bench for the monitor interrupt status block.
// Assumes the serial host model and a conversion source driven from here.
`timescale 1ns/1ns
module mis_irq_top_tb;
  // ==========================================================================
  // Clocks, stimulus and design.
  logic sys_clk = 1'b0;
  logic conv_clk = 1'b0;
  logic reset = 1'b1;
  logic conv_done = 1'b0;
  mis_pkg::mis_conv_t conv_res = '0;
  logic ext_alert_n = 1'b1;
  logic board_temp_alarm_n = 1'b1;
  logic chassis_intrusion = 1'b0;
  logic scl, sda_in, sda_out, sda_oe_n, alert_out, alert_oe_n, overtemp_shutdown_n;
  logic [7:0] pins;
  int mismatches = 0;
  int cmp_count = 0;

  // The conversion clock is unrelated to sys_clk.
  always #20 sys_clk = ~sys_clk;
  always #3 conv_clk = ~conv_clk;

  // The alert level only matters while the pin is driven.
  assign pins = {5'h00, overtemp_shutdown_n, alert_oe_n, alert_out & ~alert_oe_n};

  mis_irq_top dut (.sys_clk, .reset, .conv_clk, .conv_reset(reset), .conv_done, .conv_res,
    .ext_alert_n, .board_temp_alarm_n, .chassis_intrusion, .scl, .sda_in, .sda_out,
    .sda_oe_n, .alert_out, .alert_oe_n, .overtemp_shutdown_n);
  mis_host_model host (.sys_clk, .sda_out, .sda_oe_n, .scl, .sda_in);

  // ==========================================================================
  // Helpers.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(ofs, d);
    chk(d, exp);
  endtask : rdchk

  // One result pulse, then room for the crossing and its acknowledge to return.
  task automatic conv(input logic [6:0] v, input logic [1:0] t, input logic [3:0] tmp);
    @(posedge conv_clk);
    #1;
    conv_res = {v, t, tmp};
    conv_done = 1'b1;
    @(posedge conv_clk);
    #1;
    conv_done = 1'b0;
    tick(12);
  endtask : conv

  task automatic report_and_stop;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog: the sequence needs about 21900 cycles.
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence: reset, then one group of register accesses per behaviour.
  initial begin
    logic [3:0] tb;
    logic [7:0] fl;
    tick(10);
    reset = 1'b0;
    tick(5);
    chk(pins, 8'h06);
    for (int a = 1; a <= 4; a++) rdchk(8'(a), 8'h00);
    host.wr(8'h03, 8'hA5);
    rdchk(8'h03, 8'hA5);
    host.wr(8'h04, 8'h03);
    rdchk(8'h04, 8'h03);
    host.wr(8'h01, 8'hFF);
    rdchk(8'h01, 8'h00);
    host.wr(8'h02, 8'hFF);
    rdchk(8'h02, 8'h00);
    rdchk(8'h10, 8'h00);
    host.wr(8'h03, 8'h00);
    host.wr(8'h04, 8'h00);
    // Monitoring stays halted until the start bit is written.
    conv(7'h7F, 2'h0, 4'h0);
    rdchk(8'h01, 8'h00);
    host.wr(8'h00, 8'h03);
    conv(7'h55, 2'h3, 4'h0);
    chk(pins, 8'h04);
    rdchk(8'h01, 8'h55);
    rdchk(8'h01, 8'h00);
    rdchk(8'h02, 8'h0C);
    chk(pins, 8'h06);
    // Each pin pulses and returns idle; its bit must stay latched.
    ext_alert_n = 1'b0;
    tick(6);
    ext_alert_n = 1'b1;
    board_temp_alarm_n = 1'b0;
    tick(6);
    board_temp_alarm_n = 1'b1;
    chassis_intrusion = 1'b1;
    tick(6);
    chassis_intrusion = 1'b0;
    tick(6);
    rdchk(8'h01, 8'h80);
    rdchk(8'h02, 8'h12);
    // Masked bits latch but keep the alert quiet; then high polarity and enable.
    host.wr(8'h03, 8'hFF);
    conv(7'h7F, 2'h0, 4'h0);
    chk(pins, 8'h06);
    rdchk(8'h01, 8'h7F);
    host.wr(8'h03, 8'h00);
    host.wr(8'h00, 8'h07);
    conv(7'h01, 2'h0, 4'h0);
    chk(pins, 8'h05);
    host.wr(8'h00, 8'h05);
    chk(pins, 8'h06);
    rdchk(8'h01, 8'h01);
    host.wr(8'h00, 8'h03);
    // Hot flag first, then the shutdown flag, each in both modes.
    for (int m = 0; m < 2; m++) begin
      tb = m ? 4'h3 : 4'hC;
      fl = m ? 8'h20 : 8'h01;
      host.wr(8'h04, 8'h00);
      conv(7'h00, 2'h0, tb);
      chk(pins, m ? 8'h00 : 8'h04);
      rdchk(8'h02, fl);
      conv(7'h00, 2'h0, tb & 4'h5);
      rdchk(8'h02, fl);
      conv(7'h00, 2'h0, 4'h0);
      rdchk(8'h02, 8'h00);
      host.wr(8'h04, m ? 8'h80 : 8'h40);
      conv(7'h00, 2'h0, tb);
      rdchk(8'h02, fl);
      conv(7'h00, 2'h0, tb);
      rdchk(8'h02, 8'h00);
      conv(7'h00, 2'h0, 4'h0);
      conv(7'h00, 2'h0, tb);
      rdchk(8'h02, fl);
      conv(7'h00, 2'h0, 4'h0);
    end
    // Alert-clear releases both outputs and halts monitoring but keeps status.
    host.wr(8'h04, 8'h00);
    conv(7'h00, 2'h0, 4'h3);
    host.wr(8'h00, 8'h0B);
    chk(pins, 8'h06);
    conv(7'h01, 2'h0, 4'h0);
    rdchk(8'h01, 8'h00);
    rdchk(8'h02, 8'h20);
    chk(8'(host.nacks), 8'h00);
    report_and_stop();
  end
endmodule : mis_irq_top_tb

// ### verilog/mis_conv_cdc.sv
// Carries each conversion that finishes while the crossing is idle from the conversion clock to sys_clk.
// Assumes the conversion logic gives a one-cycle conv_done with its result.
`timescale 1ns/1ns
module mis_conv_cdc (
  input wire logic conv_clk,
  input wire logic conv_reset,
  input wire logic conv_done,
  input wire mis_pkg::mis_conv_t conv_res,
  input wire logic sys_clk,
  input wire logic reset,
  output logic res_valid,
  output mis_pkg::mis_conv_t res_word
);

  // ==========================================================================
  // Conversion side.
  logic req_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  // The acknowledge toggle lives on sys_clk; it is declared here because the
  // conversion side synchronises it first.
  logic ack_ff;
  mis_pkg::mis_conv_t hold_ff;
  logic busy;
  logic take;

  // A result that lands while the last one is still in flight is dropped;
  // the next conversion refreshes it, so nothing stale is ever shown.
  assign busy = req_ff != ack_s2_ff;
  assign take = conv_done & ~busy;

  // Hold the word and toggle the request.
  always_ff @(posedge conv_clk) begin
    if (conv_reset) begin
      req_ff <= 1'b0;
      hold_ff <= '0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
      if (take) begin
        hold_ff <= conv_res;
        req_ff <= ~req_ff;
      end
    end
  end

  // ==========================================================================
  // System side.
  logic req_s1_ff;
  logic req_s2_ff;
  logic new_req;

  // The held word is stable until the acknowledge returns, so it is safe
  // to sample it once the request toggle has been synchronised.
  assign new_req = req_s2_ff != ack_ff;

  // Copy the word and answer with the acknowledge toggle.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      ack_ff <= 1'b0;
      res_valid <= 1'b0;
      res_word <= '0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      res_valid <= new_req;
      if (new_req) begin
        res_word <= hold_ff;
        ack_ff <= req_s2_ff;
      end
    end
  end

endmodule : mis_conv_cdc

// ### verilog/mis_irq_top.sv
// Interrupt status, mask and alert pin logic of a hardware monitor.
// Assumes a host on the two-wire serial pins and conversion logic on conv_clk.
//
// Overview of operation
// [R1] Both status and both mask registers are zero after reset.
// [R2] Status 1 bits 0-6 latch voltage limit violations; software cannot write them.
// [R3] Status 1 bit 7 latches a low level on the external alert pin.
// [R4] Status 2 bit 0 flags hot temperature; mask 2 bit 6 picks its mode.
// [R5] Status 2 bit 1 latches an alarm on the shared board temperature pin.
// [R6] Status 2 bits 2 and 3 latch tachometer limit violations.
// [R7] Status 2 bit 4 latches once chassis intrusion is seen high.
// [R8] Status 2 bit 5 flags overtemperature shutdown; mask 2 bit 7 picks its mode.
// [R9] Status 2 bits 6 and 7 are reserved, read-only and read zero.
// [R10] Mask bits are read/write; a one keeps its status bit off the alert.
// [R11] Default mode re-raises the flag each conversion while above hysteresis.
// [R12] One-time mode raises once per crossing; rearms below hysteresis.
// [R13] Alert drives only when enabled; polarity picks high open-source or low open-drain.
// [R14] Alert-clear releases alert and shutdown, halts monitoring, keeps status.
// [R15] Alert asserts for any unmasked set status bit; masked bits still latch.
`timescale 1ns/1ns
module mis_irq_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2C
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic conv_clk,
  input wire logic conv_reset,
  input wire logic conv_done,
  input wire mis_pkg::mis_conv_t conv_res,
  input wire logic ext_alert_n,
  input wire logic board_temp_alarm_n,
  input wire logic chassis_intrusion,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic alert_out,
  output logic alert_oe_n,
  output logic overtemp_shutdown_n
);

  // Device addresses with the top four bits zero are reserved on the bus.
  if (DEV_ADDR[6:3] == 4'h0) begin : g_bad_addr
    $error("DEV_ADDR falls in the reserved address range");
  end

  // ==========================================================================
  // Conversion results from the conversion clock domain.
  logic res_valid;
  mis_pkg::mis_conv_t res_word;

  mis_conv_cdc u_conv_cdc (
    .conv_clk(conv_clk),
    .conv_reset(conv_reset),
    .conv_done(conv_done),
    .conv_res(conv_res),
    .sys_clk(sys_clk),
    .reset(reset),
    .res_valid(res_valid),
    .res_word(res_word)
  );

  // ==========================================================================
  // Pin synchronisers; edges are taken from the second and third stages.
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_ff;
  logic [4:0] pin_s2_ff;
  logic [4:0] pin_s3_ff;

  assign pin_raw = {chassis_intrusion, board_temp_alarm_n, ext_alert_n, sda_in, scl};

  // Two stages before any logic, one more for edge detection.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_s1_ff <= mis_pkg::PIN_IDLE;
      pin_s2_ff <= mis_pkg::PIN_IDLE;
      pin_s3_ff <= mis_pkg::PIN_IDLE;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // Bus conditions and the monitored pin levels.
  logic sda_hi;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic ext_low;
  logic bti_low;
  logic ci_high;

  assign sda_hi = pin_s2_ff[1];
  assign scl_rise = pin_s2_ff[0] & ~pin_s3_ff[0];
  assign scl_fall = ~pin_s2_ff[0] & pin_s3_ff[0];
  assign bus_start = pin_s2_ff[0] & pin_s3_ff[0] & pin_s3_ff[1] & ~pin_s2_ff[1];
  assign bus_stop = pin_s2_ff[0] & pin_s3_ff[0] & ~pin_s3_ff[1] & pin_s2_ff[1];
  assign ext_low = ~pin_s2_ff[2];
  assign bti_low = ~pin_s2_ff[3];
  assign ci_high = pin_s2_ff[4];

  // ==========================================================================
  // Two-wire serial slave: pointer write, data write, repeated data read.
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } mis_ser_state_t;

  mis_ser_state_t st_ff;
  mis_ser_state_t nxt_st;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic rw_ff;
  logic nxt_rw;
  logic wr_stb;
  logic rd_stb;
  logic byte_done;
  logic [7:0] rd_data;

  assign byte_done = bit_cnt_ff == mis_pkg::BITS_PER_BYTE;

  // Bits are sampled on SCL rising and the slave's drive changes after SCL
  // falls, so SDA only moves while SCL is low.
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_rw = rw_ff;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    if (bus_stop) begin
      nxt_st = ST_IDLE;
    end else if (bus_start) begin
      nxt_st = ST_ADDR;
      nxt_cnt = 4'h0;
    end else if (scl_rise) begin
      case (st_ff)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          nxt_shift = {shift_ff[6:0], sda_hi};
          nxt_cnt = bit_cnt_ff + 4'h1;
        end
        ST_RDATA: nxt_cnt = bit_cnt_ff + 4'h1;
        ST_RDATA_ACK: if (sda_hi) nxt_st = ST_IDLE;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_ff)
        ST_ADDR: if (byte_done) begin
          nxt_st = (shift_ff[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
          nxt_rw = shift_ff[0];
        end
        ST_PTR: if (byte_done) nxt_st = ST_PTR_ACK;
        ST_WDATA: if (byte_done) begin
          nxt_st = ST_WDATA_ACK;
          wr_stb = 1'b1;
        end
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          nxt_cnt = 4'h0;
          if (rw_ff) begin
            nxt_st = ST_RDATA;
            nxt_shift = rd_data;
            rd_stb = 1'b1;
          end else begin
            nxt_st = ST_PTR;
          end
        end
        ST_PTR_ACK: begin
          nxt_ptr = shift_ff;
          nxt_st = ST_WDATA;
          nxt_cnt = 4'h0;
        end
        ST_WDATA_ACK: begin
          nxt_st = ST_WDATA;
          nxt_cnt = 4'h0;
        end
        ST_RDATA: if (byte_done) nxt_st = ST_RDATA_ACK;
          else nxt_shift = {shift_ff[6:0], 1'b0};
        default: ;
      endcase
    end
  end

  // The slave pulls SDA low for its acknowledges and for zero data bits.
  logic nxt_sda_oe_n;
  assign nxt_sda_oe_n = ~((nxt_st == ST_ADDR_ACK) | (nxt_st == ST_PTR_ACK) |
                          (nxt_st == ST_WDATA_ACK) | ((nxt_st == ST_RDATA) & ~nxt_shift[7]));

  // Serial state registers.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      bit_cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      rw_ff <= nxt_rw;
      sda_oe_n <= nxt_sda_oe_n;
      sda_out <= 1'b0;
    end
  end

  // ==========================================================================
  // Register decode.
  logic [7:0] cfg_ff;
  logic [7:0] flags1_ff;
  logic [7:0] flags2_ff;
  logic [7:0] mask1_ff;
  logic [7:0] mask2_ff;
  logic wr_cfg;
  logic wr_mask1;
  logic wr_mask2;
  logic rd_clr1;
  logic rd_clr2;
  logic init_stb;

  assign wr_cfg = wr_stb & (ptr_ff == mis_pkg::OFS_CFG);
  assign wr_mask1 = wr_stb & (ptr_ff == mis_pkg::OFS_MASK1); // [R10]
  assign wr_mask2 = wr_stb & (ptr_ff == mis_pkg::OFS_MASK2); // [R10]
  assign rd_clr1 = rd_stb & (ptr_ff == mis_pkg::OFS_FLAGS1);
  assign rd_clr2 = rd_stb & (ptr_ff == mis_pkg::OFS_FLAGS2);
  assign init_stb = wr_cfg & shift_ff[mis_pkg::CFG_INIT];

  // Unmapped pointers read zero; writes to status offsets fall through. [R2] [R9]
  assign rd_data = (ptr_ff == mis_pkg::OFS_CFG) ? cfg_ff :
                   (ptr_ff == mis_pkg::OFS_FLAGS1) ? flags1_ff :
                   (ptr_ff == mis_pkg::OFS_FLAGS2) ? flags2_ff :
                   (ptr_ff == mis_pkg::OFS_MASK1) ? mask1_ff :
                   (ptr_ff == mis_pkg::OFS_MASK2) ? mask2_ff : mis_pkg::NO_REG;

  // ==========================================================================
  // Event sources.
  logic mon_on;
  logic [1:0] hot_step;
  logic [1:0] os_step;
  logic hot_act_ff;
  logic os_act_ff;
  logic [7:0] set1;
  logic [7:0] set2;

  // Returns {next armed state, set request} for one temperature flag.
  // Armed means the reading went over the limit and is still above hysteresis.
  function automatic logic [1:0] temp_step(input logic act, input logic over,
                                           input logic above_hyst, input logic one_time);
    logic nxt_act;
    nxt_act = over | (act & above_hyst);
    temp_step = {nxt_act, one_time ? (nxt_act & ~act) : nxt_act}; // [R11] [R12]
  endfunction : temp_step

  // Alert-clear or a stopped monitor blocks every new event. [R14]
  assign mon_on = cfg_ff[mis_pkg::CFG_START] & ~cfg_ff[mis_pkg::CFG_INT_CLR];
  assign hot_step = temp_step(hot_act_ff, res_word.hot_over, res_word.hot_hyst,
                              mask2_ff[mis_pkg::M2_HOT_MODE]); // [R4]
  assign os_step = temp_step(os_act_ff, res_word.os_over, res_word.os_hyst,
                             mask2_ff[mis_pkg::M2_OS_MODE]); // [R8]

  // Status set terms; masks never take part here, so masked bits latch. [R15]
  assign set1 = mon_on ? {ext_low, res_valid ? res_word.volt : 7'h00} : 8'h00; // [R2] [R3]
  assign set2 = mon_on ? {2'b00, os_step[0] & res_valid, ci_high, // [R7] [R8] [R9]
                          res_valid ? res_word.tach : 2'b00, bti_low, // [R5] [R6]
                          hot_step[0] & res_valid} : 8'h00; // [R4]

  // Armed states advance once per finished conversion while monitoring is on.
  always_ff @(posedge sys_clk) begin
    if (reset || init_stb) begin
      hot_act_ff <= 1'b0;
      os_act_ff <= 1'b0;
    end else if (res_valid && mon_on) begin
      hot_act_ff <= hot_step[1]; // [R12]
      os_act_ff <= os_step[1];
    end
  end

  // ==========================================================================
  // Registers; a set in the cycle of a read clear wins over the clear.
  logic [7:0] nxt_flags1;
  logic [7:0] nxt_flags2;

  assign nxt_flags1 = (flags1_ff & {8{~rd_clr1}}) | set1;
  assign nxt_flags2 = ((flags2_ff & {8{~rd_clr2}}) | set2) & mis_pkg::F2_USED; // [R9]

  // The initialise bit restores defaults and clears itself.
  always_ff @(posedge sys_clk) begin
    if (reset || init_stb) begin
      cfg_ff <= mis_pkg::CFG_RST;
      flags1_ff <= mis_pkg::FLAGS_RST; // [R1]
      flags2_ff <= mis_pkg::FLAGS_RST; // [R1]
      mask1_ff <= mis_pkg::MASK_RST; // [R1]
      mask2_ff <= mis_pkg::MASK_RST; // [R1]
    end else begin
      flags1_ff <= nxt_flags1;
      flags2_ff <= nxt_flags2;
      if (wr_cfg) cfg_ff <= shift_ff;
      if (wr_mask1) mask1_ff <= shift_ff; // [R10]
      if (wr_mask2) mask2_ff <= shift_ff; // [R10]
    end
  end

  // ==========================================================================
  // Alert and shutdown pins.
  logic pending;
  logic alert_act;

  assign pending = |(flags1_ff & ~mask1_ff) | |(flags2_ff & ~mask2_ff & mis_pkg::F2_USED); // [R15]
  assign alert_act = cfg_ff[mis_pkg::CFG_INT_EN] & ~cfg_ff[mis_pkg::CFG_INT_CLR] & pending; // [R13]

  // Released pin floats; the polarity sets the level driven when active.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alert_out <= 1'b0;
      alert_oe_n <= 1'b1;
      overtemp_shutdown_n <= 1'b1;
    end else begin
      alert_out <= cfg_ff[mis_pkg::CFG_POL]; // [R13]
      alert_oe_n <= ~alert_act; // [R13]
      overtemp_shutdown_n <= ~(flags2_ff[mis_pkg::F2_OS] & ~cfg_ff[mis_pkg::CFG_INT_CLR]); // [R14]
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_reset_regs_zero: assert property ($fell(reset) |-> // [R1]
    (flags1_ff == 8'h00) && (flags2_ff == 8'h00) && (mask1_ff == 8'h00) && (mask2_ff == 8'h00))
    else $error("status or mask not zero after reset");
  a_volt_latch: assert property (res_valid && mon_on |=> // [R2]
    ((flags1_ff[6:0] & $past(res_word.volt)) == $past(res_word.volt)))
    else $error("voltage violation not latched");
  a_volt_no_write: assert property (wr_stb && (ptr_ff == mis_pkg::OFS_FLAGS1) && !mon_on |=> // [R2]
    flags1_ff == $past(flags1_ff)) else $error("status 1 changed by a write");
  a_ext_latch: assert property (mon_on && ext_low |=> flags1_ff[mis_pkg::F1_EXT]) // [R3]
    else $error("external alert not latched");
  a_bti_latch: assert property (mon_on && bti_low |=> flags2_ff[mis_pkg::F2_BTI]) // [R5]
    else $error("board alarm not latched");
  a_tach_latch: assert property (res_valid && mon_on |=> // [R6]
    ((flags2_ff[3:2] & $past(res_word.tach)) == $past(res_word.tach)))
    else $error("tach violation not latched");
  a_chassis_latch: assert property (mon_on && ci_high |=> flags2_ff[mis_pkg::F2_CHASSIS]) // [R7]
    else $error("chassis intrusion not latched");
  a_reserved_zero: assert property (flags2_ff[7:6] == 2'b00) // [R9]
    else $error("reserved status bits set");
  a_hot_default: assert property (res_valid && mon_on && !mask2_ff[mis_pkg::M2_HOT_MODE] && // [R11]
    (res_word.hot_over || (hot_act_ff && res_word.hot_hyst)) |=> flags2_ff[mis_pkg::F2_HOT])
    else $error("default mode hot flag not raised");
  a_hot_once: assert property (res_valid && mask2_ff[mis_pkg::M2_HOT_MODE] && hot_act_ff && // [R12]
    !flags2_ff[mis_pkg::F2_HOT] |=> !flags2_ff[mis_pkg::F2_HOT])
    else $error("one-time hot flag raised twice");
  a_hot_mode_once: assert property (res_valid && mon_on && mask2_ff[mis_pkg::M2_HOT_MODE] && // [R4]
    !hot_act_ff && res_word.hot_over |=> flags2_ff[mis_pkg::F2_HOT] && hot_act_ff)
    else $error("one-time hot flag missed a crossing");
  a_os_default: assert property (res_valid && mon_on && !mask2_ff[mis_pkg::M2_OS_MODE] && // [R8]
    (res_word.os_over || (os_act_ff && res_word.os_hyst)) |=> flags2_ff[mis_pkg::F2_OS])
    else $error("default mode shutdown flag not raised");
  a_alert_unmasked: assert property (alert_act |=> !alert_oe_n && // [R15]
    (alert_out == $past(cfg_ff[mis_pkg::CFG_POL]))) else $error("alert not driven");
  a_alert_masked: assert property (!pending |=> alert_oe_n) // [R10]
    else $error("alert driven with nothing unmasked");
  a_alert_enable: assert property (!cfg_ff[mis_pkg::CFG_INT_EN] |=> alert_oe_n) // [R13]
    else $error("alert driven while disabled");
  a_clear_halts: assert property (cfg_ff[mis_pkg::CFG_INT_CLR] && !rd_stb && !init_stb |=> // [R14]
    (flags1_ff == $past(flags1_ff)) && alert_oe_n && overtemp_shutdown_n)
    else $error("alert-clear did not halt and release");

endmodule : mis_irq_top

// ### verilog/mis_pkg.sv
// Shared constants and carrier types for the monitor interrupt status block.
// Assumes one system clock domain and one conversion clock domain.
package mis_pkg;

  // ==========================================================================
  // Register offsets on the serial port.
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_FLAGS1 = 8'h01;
  localparam logic [7:0] OFS_FLAGS2 = 8'h02;
  localparam logic [7:0] OFS_MASK1 = 8'h03;
  localparam logic [7:0] OFS_MASK2 = 8'h04;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] CFG_RST = 8'h08;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] NO_REG = 8'h00;

  // ==========================================================================
  // Field positions.
  localparam logic [2:0] CFG_START = 3'h0;
  localparam logic [2:0] CFG_INT_EN = 3'h1;
  localparam logic [2:0] CFG_POL = 3'h2;
  localparam logic [2:0] CFG_INT_CLR = 3'h3;
  localparam logic [2:0] CFG_INIT = 3'h7;
  localparam logic [2:0] F1_EXT = 3'h7;
  localparam logic [2:0] F2_HOT = 3'h0;
  localparam logic [2:0] F2_BTI = 3'h1;
  localparam logic [2:0] F2_CHASSIS = 3'h4;
  localparam logic [2:0] F2_OS = 3'h5;
  localparam logic [2:0] M2_HOT_MODE = 3'h6;
  localparam logic [2:0] M2_OS_MODE = 3'h7;
  localparam logic [7:0] F2_USED = 8'h3F;

  // ==========================================================================
  // Serial port timing and pin idle levels {ci, bti_n, ext_n, sda, scl}.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [4:0] PIN_IDLE = 5'h0F;

  // One finished conversion as seen by the status logic.
  typedef struct packed {
    logic [6:0] volt;
    logic [1:0] tach;
    logic hot_over;
    logic hot_hyst;
    logic os_over;
    logic os_hyst;
  } mis_conv_t;

endpackage : mis_pkg
